/* File: hw/utxrx_datapath.v */
// serial transmit and receive data path with an avalon-mm register slave
`timescale 1ns/1ps
`include "utxrx_regs.vh"

// Summary of operation
// - buffer-empty flag is set while the transmit buffer holds no data
// - buffer-empty interrupt requested while its enable and the flag are set
// - writing the data register clears the buffer-empty flag
// - transmit complete set when frame has left and buffer is empty
// - transmit complete clears on interrupt service or on writing one
// - transmit complete interrupt requested when enabled and the flag is set
// - parity bit inserted after last data bit, before first stop bit
// - clearing transmitter enable waits until shifter and buffer are empty
// - transmitter releases the serial output pin once actually disabled
// - receiver enable turns receiver on and takes over the serial input
// - in synchronous mode the external serial clock pin clocks transfers
// - receiver starts on valid start bit and shifts bits until first stop
// - second stop bit is ignored; frame completes at first stop bit
// - at first stop bit the shift register moves into the receive buffer
// - unused upper bits of short characters read as zero
// - shifter loads buffered data when idle or right after last stop bit
// - frame starts with one start bit, then data least significant first
// - parity is xor of data bits, inverted for odd parity
// - receive complete flag is one while unread data remain; disabling the receiver clears it
module utxrx_datapath (
  input wire core_clk,
  input wire arst_n,
  input wire [`UTXRX_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire globalIrqEn,
  input wire txcIrqAck,
  output wire bufEmptyIrq,
  output wire txCompleteIrq,
  input wire serialInPin,
  input wire extSerialClockPin,
  output wire serialOutPin,
  output wire serialOutEn,
  output wire serialInOwned
);
  localparam ST_IDLE = 2'h0;
  localparam ST_DATA = 2'h1;
  localparam ST_PAR = 2'h2;
  localparam ST_STOP = 2'h3;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  reg ackPend_reg;
  wire rdAcc = avs_read & ackPend_reg;
  wire wrAcc = avs_write & ackPend_reg;
  reg [7:0] ctrlB_reg;
  reg [7:0] ctrlC_reg;
  reg [7:0] txBuf_reg;
  reg txBuf8_reg;
  reg txFull_reg;
  reg txc_reg;
  reg txOn_reg;
  reg [8:0] rxBuf_reg;
  reg rxc_reg;
  wire [2:0] charCode = {ctrlB_reg[`UTXRX_CB_CSZ2], ctrlC_reg[`UTXRX_CC_CSZ0+1],
    ctrlC_reg[`UTXRX_CC_CSZ0]};
  wire [3:0] nBits = (charCode == 3'h7) ? 4'h9 : ((charCode > 3'h3) ? 4'h8 : {2'h0,
    charCode[1:0]} + 4'h5);
  wire isSync = ctrlC_reg[`UTXRX_CC_SYNC];

  // one wait cycle per access keeps timing fixed
  assign avs_waitrequest = (avs_read | avs_write) & ~ackPend_reg;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ackPend_reg <= 1'b0;
    end else begin
      ackPend_reg <= (avs_read | avs_write) & ~ackPend_reg;
    end
  end

  wire [7:0] statusVal = {rxc_reg, txc_reg, ~txFull_reg, 5'h00};
  wire [7:0] rxMask = (nBits >= 4'h8) ? 8'hFF : ((8'h01 << nBits[2:0]) - 8'h01);
  // load during the wait cycle so the data stand at the accepting edge
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read && !ackPend_reg) begin
      case (avs_address)
        `UTXRX_OFF_STATUS: avs_readdata <= {24'h000000, statusVal};
        `UTXRX_OFF_CTRLB: avs_readdata <= {24'h000000, ctrlB_reg[7:2],
          rxBuf_reg[8], ctrlB_reg[0]};
        `UTXRX_OFF_CTRLC: avs_readdata <= {24'h000000, ctrlC_reg};
        `UTXRX_OFF_DATA: avs_readdata <= {24'h000000, rxBuf_reg[7:0] & rxMask};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlB_reg <= `UTXRX_CB_RESET;
      ctrlC_reg <= `UTXRX_CC_RESET;
    end else if (wrAcc && avs_address == `UTXRX_OFF_CTRLB) begin
      ctrlB_reg <= avs_writedata[7:0];
    end else if (wrAcc && avs_address == `UTXRX_OFF_CTRLC) begin
      ctrlC_reg <= avs_writedata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // bit timing: internal divider or synchronised external clock
  // ----------------------------------------------------------------
  reg xck1_reg;
  reg xck2_reg;
  reg xck3_reg;
  reg [11:0] baudCnt_reg;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      xck1_reg <= 1'b0;
      xck2_reg <= 1'b0;
      xck3_reg <= 1'b0;
      baudCnt_reg <= 12'h000;
    end else begin
      xck1_reg <= extSerialClockPin;
      xck2_reg <= xck1_reg;
      xck3_reg <= xck2_reg;
      baudCnt_reg <= (baudCnt_reg == 12'h000) ? `UTXRX_BAUD_DIV_RESET : baudCnt_reg - 12'h001;
    end
  end
  // change on rising, sample on falling external edge
  wire txTick = isSync ? (xck2_reg & ~xck3_reg) : (baudCnt_reg == 12'h000);
  wire rxTick = isSync ? (~xck2_reg & xck3_reg) : (baudCnt_reg == 12'h000);

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  reg [1:0] txState_reg;
  reg [8:0] txShift_reg;
  reg [3:0] txCnt_reg;
  reg txPar_reg;
  reg txLine_reg;
  wire dataWr = wrAcc && avs_address == `UTXRX_OFF_DATA;
  wire stWr = wrAcc && avs_address == `UTXRX_OFF_STATUS;
  wire txEnBit = ctrlB_reg[`UTXRX_CB_TRANSMITTER_ENABLE];
  wire txLastStop = txTick && txState_reg == ST_STOP && (txCnt_reg == 4'h0 ||
    !ctrlC_reg[`UTXRX_CC_USBS]);
  wire txLoad = txFull_reg && txOn_reg && txTick && (txState_reg == ST_IDLE || txLastStop);
  wire txDone = txLastStop && !txFull_reg;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txBuf_reg <= 8'h00;
      txBuf8_reg <= 1'b0;
      txFull_reg <= 1'b0;
    end else begin
      if (dataWr) begin
        txBuf_reg <= avs_writedata[7:0];
        txBuf8_reg <= ctrlB_reg[`UTXRX_CB_TX_NINTH_BIT];
        txFull_reg <= 1'b1;
      end else if (txLoad) begin
        txFull_reg <= 1'b0;
      end
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txc_reg <= 1'b0;
    end else if (txDone) begin
      txc_reg <= 1'b1;
    end else if (txcIrqAck || (stWr && avs_writedata[`UTXRX_ST_TXC])) begin
      txc_reg <= 1'b0;
    end
  end

  // the enable drops only once nothing is left to send
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txOn_reg <= 1'b0;
    end else if (txEnBit) begin
      txOn_reg <= 1'b1;
    end else if (!txFull_reg && txState_reg == ST_IDLE) begin
      txOn_reg <= 1'b0;
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      txState_reg <= ST_IDLE;
      txShift_reg <= 9'h000;
      txCnt_reg <= 4'h0;
      txPar_reg <= 1'b0;
      txLine_reg <= 1'b1;
    end else if (txLoad) begin
      txShift_reg <= {txBuf8_reg, txBuf_reg};
      txCnt_reg <= nBits;
      txPar_reg <= ctrlC_reg[`UTXRX_CC_PAR_ODD];
      txLine_reg <= 1'b0;
      txState_reg <= ST_DATA;
    end else if (txTick) begin
      case (txState_reg)
        ST_IDLE: begin
          txLine_reg <= 1'b1;
        end
        ST_DATA: begin
          if (txCnt_reg == 4'h0) begin
            if (ctrlC_reg[`UTXRX_CC_PAR_EN]) begin
              txLine_reg <= txPar_reg;
              txState_reg <= ST_PAR;
            end else begin
              txLine_reg <= 1'b1;
              txCnt_reg <= 4'h1;
              txState_reg <= ST_STOP;
            end
          end else begin
            txLine_reg <= txShift_reg[0];
            txPar_reg <= txPar_reg ^ txShift_reg[0];
            txShift_reg <= {1'b0, txShift_reg[8:1]};
            txCnt_reg <= txCnt_reg - 4'h1;
          end
        end
        ST_PAR: begin
          txLine_reg <= 1'b1;
          txCnt_reg <= 4'h1;
          txState_reg <= ST_STOP;
        end
        ST_STOP: begin
          if (txLastStop) begin
            txState_reg <= ST_IDLE;
          end else begin
            txCnt_reg <= 4'h0;
          end
        end
        default: txState_reg <= ST_IDLE;
      endcase
    end
  end

  assign serialOutPin = txLine_reg;
  assign serialOutEn = txOn_reg;
  assign bufEmptyIrq = globalIrqEn & ctrlB_reg[`UTXRX_CB_UDRIE] & ~txFull_reg;
  assign txCompleteIrq = globalIrqEn & ctrlB_reg[`UTXRX_CB_TXCIE] & txc_reg;

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  reg rxd1_reg;
  reg rxd2_reg;
  reg [1:0] rxState_reg;
  reg [8:0] rxShift_reg;
  reg [3:0] rxCnt_reg;
  wire rxOn = ctrlB_reg[`UTXRX_CB_RXEN];
  wire dataRd = rdAcc && avs_address == `UTXRX_OFF_DATA;
  assign serialInOwned = rxOn;
  wire rxFrameEnd = rxTick && rxState_reg == ST_STOP;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxd1_reg <= 1'b1;
      rxd2_reg <= 1'b1;
    end else begin
      rxd1_reg <= serialInPin;
      rxd2_reg <= rxd1_reg;
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxState_reg <= ST_IDLE;
      rxShift_reg <= 9'h000;
      rxCnt_reg <= 4'h0;
    end else if (!rxOn) begin
      rxState_reg <= ST_IDLE;
    end else if (rxTick) begin
      case (rxState_reg)
        ST_IDLE: begin
          if (!rxd2_reg) begin
            rxCnt_reg <= nBits;
            rxShift_reg <= 9'h000;
            rxState_reg <= ST_DATA;
          end
        end
        ST_DATA: begin
          rxShift_reg <= {rxd2_reg, rxShift_reg[8:1]};
          rxCnt_reg <= rxCnt_reg - 4'h1;
          if (rxCnt_reg == 4'h1) begin
            rxState_reg <= ctrlC_reg[`UTXRX_CC_PAR_EN] ? ST_PAR : ST_STOP;
          end
        end
        ST_PAR: rxState_reg <= ST_STOP;
        ST_STOP: rxState_reg <= ST_IDLE;
        default: rxState_reg <= ST_IDLE;
      endcase
    end
  end

  // right-align the shifted character by its length
  wire [8:0] rxAligned = rxShift_reg >> (4'h9 - nBits);
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rxBuf_reg <= 9'h000;
      rxc_reg <= 1'b0;
    end else if (rxOn && rxFrameEnd) begin
      rxBuf_reg <= rxAligned;
      rxc_reg <= 1'b1;
    end else if (dataRd || !rxOn) begin
      rxc_reg <= 1'b0;
    end
  end
endmodule // utxrx_datapath

/* File: common/utxrx_regs.vh */
// register offsets, field positions, reset values and timing counts of the serial data path
`ifndef UTXRX_REGS_VH
`define UTXRX_REGS_VH
`define UTXRX_ADDR_W 2
`define UTXRX_OFF_STATUS 2'h0
`define UTXRX_OFF_CTRLB 2'h1
`define UTXRX_OFF_CTRLC 2'h2
`define UTXRX_OFF_DATA 2'h3
// status fields
`define UTXRX_ST_TXC 6
`define UTXRX_ST_UDRE 5
`define UTXRX_ST_RXC 7
// control b fields
`define UTXRX_CB_TX_NINTH_BIT 0
`define UTXRX_CB_RXB8 1
`define UTXRX_CB_CSZ2 2
`define UTXRX_CB_TRANSMITTER_ENABLE 3
`define UTXRX_CB_RXEN 4
`define UTXRX_CB_UDRIE 5
`define UTXRX_CB_TXCIE 6
// control c fields
`define UTXRX_CC_CSZ0 1
`define UTXRX_CC_USBS 3
`define UTXRX_CC_PAR_ODD 4
`define UTXRX_CC_PAR_EN 5
`define UTXRX_CC_SYNC 6
`define UTXRX_CB_RESET 8'h00
`define UTXRX_CC_RESET 8'h06
`define UTXRX_BAUD_DIV_RESET 12'h00F
`define UTXRX_OFF_BAUD 2'h2
`endif

/* File: tb/utxrx_checker.sv */
// port assertions of the serial data path
`timescale 1ns/1ps
`include "utxrx_regs.vh"
module utxrx_checker (
  input wire core_clk,
  input wire arst_n,
  input wire [`UTXRX_ADDR_W-1:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire avs_waitrequest,
  input wire globalIrqEn,
  input wire txcIrqAck,
  input wire bufEmptyIrq,
  input wire txCompleteIrq,
  input wire serialOutPin,
  input wire serialOutEn,
  input wire serialInOwned
);
  // cycles the output line has stayed high
  reg [4:0] hiCnt_reg;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) hiCnt_reg <= 5'h00;
    else if (!serialOutPin) hiCnt_reg <= 5'h00;
    else if (hiCnt_reg != 5'h1F) hiCnt_reg <= hiCnt_reg + 5'h01;
  end
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_req; (avs_read || avs_write) && !$past(avs_read || avs_write); endsequence
  sequence s_ack; (avs_read || avs_write) && !avs_waitrequest; endsequence
  sequence s_cbWr; avs_write && !avs_waitrequest && avs_address == `UTXRX_OFF_CTRLB; endsequence
  property p_wait; s_req |-> avs_waitrequest ##1 s_ack; endproperty
  a_wait: assert property (p_wait) else $error("bus answer not after one wait");
  property p_own; s_cbWr |=> serialInOwned == $past(avs_writedata[`UTXRX_CB_RXEN]); endproperty
  a_own: assert property (p_own) else $error("input pin ownership wrong");
  property p_glob; !globalIrqEn |-> !bufEmptyIrq && !txCompleteIrq; endproperty
  a_glob: assert property (p_glob) else $error("request without global enable");
  property p_beHold; bufEmptyIrq && !avs_write ##1 globalIrqEn |-> bufEmptyIrq; endproperty
  a_beHold: assert property (p_beHold) else $error("empty request dropped");
  property p_tcHold;
    txCompleteIrq && !avs_write && !txcIrqAck ##1 globalIrqEn |-> txCompleteIrq;
  endproperty
  a_tcHold: assert property (p_tcHold) else $error("complete request dropped");
  property p_tcAck; txcIrqAck && txCompleteIrq |=> !txCompleteIrq; endproperty
  a_tcAck: assert property (p_tcAck) else $error("service kept complete flag");
  property p_tcSet;
    $rose(txCompleteIrq) && $stable(globalIrqEn) && !$past(avs_write) |-> hiCnt_reg >= 5'h0C;
  endproperty
  a_tcSet: assert property (p_tcSet) else $error("complete before stop bit");
  property p_low; $fell(serialOutPin) |-> !serialOutPin [*8]; endproperty
  a_low: assert property (p_low) else $error("short low bit on line");
  property p_rel; $fell(serialOutEn) |-> serialOutPin && hiCnt_reg >= 5'h0C; endproperty
  a_rel: assert property (p_rel) else $error("pin released mid frame");
endmodule // utxrx_checker
bind utxrx_datapath utxrx_checker u_chk (.core_clk(core_clk), .arst_n(arst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .globalIrqEn(globalIrqEn), .txcIrqAck(txcIrqAck), .bufEmptyIrq(bufEmptyIrq),
  .txCompleteIrq(txCompleteIrq), .serialOutPin(serialOutPin),
  .serialOutEn(serialOutEn), .serialInOwned(serialInOwned));

/* File: tb/utxrx_remote.sv */
// remote serial device: sends frames to the block and collects its frames
`timescale 1ns/1ps
module utxrx_remote (
  input wire clk,
  input wire txd,
  input wire [3:0] len,
  output reg rxd,
  output reg [10:0] got,
  output reg [7:0] gotN
);
  integer i;
  initial begin
    rxd = 1'h1;
    gotN = 8'h00;
  end
  // 16 clocks a bit, sampled mid-bit up to the first stop bit
  always begin
    @(negedge txd);
    repeat (8) @(posedge clk);
    got = 11'h000;
    for (i = 0; i <= len; i++) begin
      repeat (16) @(posedge clk);
      got[i] = txd;
    end
    gotN = gotN + 8'h01;
  end
  // least significant first; the last stop bit leaves the line idle high
  task send(input [13:0] f, input integer n);
    integer k;
    for (k = 0; k < n; k++) begin
      @(posedge clk);
      rxd <= f[k];
      repeat (15) @(posedge clk);
    end
  endtask
endmodule // utxrx_remote

/* File: tb/utxrx_datapath_tb_top.sv */
// self-checking bench of the serial data path
`timescale 1ns/1ps
`include "utxrx_regs.vh"
module utxrx_datapath_tb_top;
  reg core_clk = 1'h0, arst_n = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  reg globalIrqEn = 1'h0, txcIrqAck = 1'h0, pen, odd, two;
  reg [1:0] avs_address = 2'h0;
  reg [31:0] avs_writedata = 32'h0, q;
  reg [3:0] remLen = 4'h8;
  reg [3:0] xClk = 4'h0;
  reg [7:0] k, cb;
  reg [8:0] w, w2;
  wire [31:0] avs_readdata;
  wire avs_waitrequest, bufEmptyIrq, txCompleteIrq, serialInPin;
  wire serialOutPin, serialOutEn, serialInOwned;
  wire [10:0] remGot;
  wire [7:0] remN;
  integer failCount = 0, checksDone = 0, seed = 14, i, n, b;
  always #25 core_clk = ~core_clk;
  // free external serial clock: one period every 16 core cycles
  always @(posedge core_clk) xClk <= xClk + 4'h1;
  utxrx_datapath uut (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .globalIrqEn(globalIrqEn), .txcIrqAck(txcIrqAck), .bufEmptyIrq(bufEmptyIrq),
    .txCompleteIrq(txCompleteIrq), .serialInPin(serialInPin), .extSerialClockPin(xClk[3]),
    .serialOutPin(serialOutPin), .serialOutEn(serialOutEn), .serialInOwned(serialInOwned));
  utxrx_remote rem (.clk(core_clk), .txd(serialOutPin), .len(remLen), .rxd(serialInPin),
    .got(remGot), .gotN(remN));
  task chk(input [31:0] got, input [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value at %0t: %h against %h", $time, got, exp);
    end
  endtask
  // one request held until waitrequest is sampled low at a rising edge
  task bus(input wr, input [1:0] a, input [7:0] d);
    @(posedge core_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    do @(posedge core_clk); while (avs_waitrequest !== 1'h0);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(negedge core_clk);
  endtask
  // data, parity and first stop bit as they appear on the line
  function [10:0] ef(input [8:0] v, input integer nb, input p, input o);
    ef = {2'h0, v} & ((11'h001 << nb) - 11'h001);
    if (p) ef[nb] = ^ef ^ o;
    ef[nb + p] = 1'h1;
  endfunction
  task finishTest;
    $display("checks %0d errors %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge core_clk);
    failCount++;
    finishTest;
  end
  initial begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'h1;
    bus(1'h0, `UTXRX_OFF_STATUS, 8'h00);
    chk(q, 32'h20);
    bus(1'h1, `UTXRX_OFF_CTRLB, 8'h78);
    chk(bufEmptyIrq, 1'h0);
    chk(serialInOwned, 1'h1);
    @(posedge core_clk) globalIrqEn <= 1'h1;
    for (i = 0; i < 10; i++) begin
      n = 5 + i % 5;
      b = $random(seed);
      {pen, odd, two} = b[2:0];
      w = $random(seed);
      w2 = $random(seed);
      w2[8] = w[8];
      cb = 8'h78 | {5'h00, n == 9, 1'h0, w[8]};
      remLen <= n[3:0] + {3'h0, pen};
      bus(1'h1, `UTXRX_OFF_CTRLC, {1'h0, i > 6, pen, odd, two,
        (n == 9) ? 2'h3 : n[1:0] - 2'h1, 1'h0});
      bus(1'h1, `UTXRX_OFF_CTRLB, cb);
      chk(bufEmptyIrq, 1'h1);
      k = remN;
      fork
        rem.send((14'h3FFF << (n + pen + 1)) | {ef(w, n, pen, odd), 1'h0}, n + pen + 2 + two);
      join_none
      bus(1'h1, `UTXRX_OFF_DATA, w[7:0]);
      while (bufEmptyIrq !== 1'h1) @(negedge core_clk);
      bus(1'h1, `UTXRX_OFF_DATA, w2[7:0]);
      chk(bufEmptyIrq, 1'h0);
      bus(1'h0, `UTXRX_OFF_STATUS, 8'h00);
      chk(q[5], 1'h0);
      wait (remN == k + 8'h01);
      chk(remGot, ef(w, n, pen, odd));
      wait (remN == k + 8'h02);
      chk(remGot, ef(w2, n, pen, odd));
      while (txCompleteIrq !== 1'h1) @(negedge core_clk);
      bus(1'h0, `UTXRX_OFF_STATUS, 8'h00);
      chk(q[7:5], 3'h7);
      bus(1'h0, `UTXRX_OFF_CTRLB, 8'h00);
      if (n == 9) chk(q[1], w[8]);
      bus(1'h0, `UTXRX_OFF_DATA, 8'h00);
      chk(q, w[7:0] & ((9'h001 << n) - 9'h001));
      if (i % 2) bus(1'h1, `UTXRX_OFF_STATUS, 8'h40);
      else begin
        @(posedge core_clk) txcIrqAck <= 1'h1;
        @(posedge core_clk) txcIrqAck <= 1'h0;
      end
      bus(1'h0, `UTXRX_OFF_STATUS, 8'h00);
      chk(q[7:6], 2'h0);
    end
    k = remN;
    bus(1'h1, `UTXRX_OFF_DATA, w[7:0]);
    while (bufEmptyIrq !== 1'h1) @(negedge core_clk);
    bus(1'h1, `UTXRX_OFF_DATA, w2[7:0]);
    bus(1'h1, `UTXRX_OFF_CTRLB, cb & 8'h97);
    chk(serialOutEn, 1'h1);
    wait (remN == k + 8'h02);
    chk(remGot, ef(w2, n, pen, odd));
    while (serialOutEn !== 1'h0) @(negedge core_clk);
    chk(serialOutPin, 1'h1);
    bus(1'h1, `UTXRX_OFF_CTRLB, 8'h00);
    chk(serialInOwned, 1'h0);
    finishTest;
  end
endmodule // utxrx_datapath_tb_top
